// ---- hw/dmm_pkg.sv ----
// Shared constants and carrier types for the dual MII MAC port block
package dmm_pkg;
  // ----------------------------------------------------------------
  // Widths and depths
  // ----------------------------------------------------------------
  localparam int NIB_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int PRE_NIBS = 15;         // Preamble nibbles before the SFD
  localparam logic [3:0] PRE_NIB = 4'h5;
  localparam logic [3:0] SFD_NIB = 4'hd;
  // Management clock divider: half period in core cycles
  localparam int MDC_HALF = 25;
  localparam logic [7:0] MDC_HALF_C = 8'h19;
  localparam logic [5:0] MGMT_BITS = 6'h20;
  localparam logic [5:0] HASH_BITS = 6'h06;

  // ----------------------------------------------------------------
  // Carrier and state types
  // ----------------------------------------------------------------
  // One nibble of a frame with its end-of-frame mark
  typedef struct packed {
    logic last;
    logic [3:0] nib;
  } dmm_word_s;

  // Line status seen from the PHY, after synchronising
  typedef struct packed {
    logic carrier;
    logic collision;
  } dmm_line_s;

  typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_SFD, TX_DATA} dmm_tx_e;
  typedef enum logic [1:0] {MG_IDLE, MG_SHIFT, MG_DONE} dmm_mg_e;
endpackage

// ---- hw/dmm_fifo.sv ----
// Small flop-based FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dmm_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  wire do_wr;
  wire do_rd;

  // Handshake decode; full and empty come straight from the count
  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem_reg[rd_reg];

  // Storage
  always_ff @(posedge mclk) begin
    if (do_wr) mem_reg[wr_reg] <= in_data;
  end

  // Pointers and count
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_wr) wr_reg <= wr_reg + 1'b1;
      if (do_rd) rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule
`default_nettype wire

// ---- hw/dmm_port.sv ----
// Dual MII MAC port: two nibble ports and one shared management line
//
// Function
// [RQ1] The PHY supplies each transmit clock at 25 MHz or 2.5 MHz.
// [RQ2] The PHY supplies each receive clock at 25 MHz or 2.5 MHz.
// [RQ3] Transmit nibbles change in step with the port's transmit clock.
// [RQ4] Transmit enable rises with the first preamble nibble, holds to the end.
// [RQ5] Receive nibbles are sampled in step with the port's receive clock.
// [RQ6] Receive nibbles count as frame data only while receive valid is high.
// [RQ7] The PHY raises collision whenever it sees one on the medium.
// [RQ8] The PHY holds carrier sense while either medium is active.
// [RQ9] The PHY holds carrier sense for the whole of a collision.
// [RQ10] Carrier sense is synchronised before any logic uses it.
// [RQ11] One shared management data line carries write data to both PHYs.
// [RQ12] The management clock drives the data line out and samples it in.
// [RQ13] The management clock pin stays an input until software enables it.
// [RQ14] The first port has no address hashing.
// [RQ15] The second port has address hashing.
// [RQ16] Exactly one management interface is shared by both ports.
// [RQ17] PHY clocked logic crosses safely into the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module dmm_port (
  // Core clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Port 0 PHY pins
  input wire logic port0_tx_clock_in,
  output logic [3:0] port0_tx_nibble,
  output logic port0_tx_enable,
  input wire logic port0_rx_clock_in,
  input wire logic [3:0] port0_rx_nibble,
  input wire logic port0_rx_valid,
  input wire logic port0_collision,
  input wire logic port0_carrier_sense,
  // Port 1 PHY pins
  input wire logic port1_tx_clock_in,
  output logic [3:0] port1_tx_nibble,
  output logic port1_tx_enable,
  input wire logic port1_rx_clock_in,
  input wire logic [3:0] port1_rx_nibble,
  input wire logic port1_rx_valid,
  input wire logic port1_collision,
  input wire logic port1_carrier_sense,
  // Shared management pins, enables low while driving
  input wire logic mgmt_data_line_i,
  output logic mgmt_data_line_o,
  output logic mgmt_data_line_oe_n,
  input wire logic mgmt_clock_line_i,
  output logic mgmt_clock_line_o,
  output logic mgmt_clock_line_oe_n,
  // User transmit streams, one per port
  input wire logic [1:0] tx_valid,
  output logic [1:0] tx_ready,
  input wire dmm_pkg::dmm_word_s [1:0] tx_word,
  // User receive streams
  output logic [1:0] rx_valid,
  input wire logic [1:0] rx_ready,
  output dmm_pkg::dmm_word_s [1:0] rx_word,
  output dmm_pkg::dmm_line_s [1:0] line_status,
  output logic [5:0] port1_hash,
  // Management command
  input wire logic mgmt_clock_drive_en,
  input wire logic mgmt_start,
  input wire logic [31:0] mgmt_frame,
  input wire logic [31:0] mgmt_out_en,
  output logic mgmt_busy,
  output logic [31:0] mgmt_read_data
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [17:0] pin_raw;
  logic [17:0] s1_reg;
  logic [17:0] s2_reg;
  logic [17:0] s3_reg;
  assign pin_raw = {port1_rx_valid, port1_rx_nibble, port1_rx_clock_in,
                    port1_tx_clock_in, port1_collision, port1_carrier_sense,
                    port0_rx_valid, port0_rx_nibble, port0_rx_clock_in,
                    port0_tx_clock_in, port0_collision, port0_carrier_sense};

  // Two stages before any use, third stage only for edge finding
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pin_raw; // [RQ10] [RQ17]
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Management pins get their own pair of stages
  logic [1:0] m1_reg;
  logic [1:0] m2_reg;
  logic mdc_old_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      m1_reg <= '0;
      m2_reg <= '0;
      mdc_old_reg <= 1'b0;
    end else begin
      m1_reg <= {mgmt_clock_line_i, mgmt_data_line_i};
      m2_reg <= m1_reg;
      mdc_old_reg <= m2_reg[1];
    end
  end

  // ----------------------------------------------------------------
  // Per-port logic
  // ----------------------------------------------------------------
  // Nine bits per port slice, low to high: crs, col, txc, rxc, nib, dv
  wire [8:0] p_now [2];
  wire [8:0] p_old [2];
  assign p_now[0] = s2_reg[8:0];
  assign p_now[1] = s2_reg[17:9];
  assign p_old[0] = s3_reg[8:0];
  assign p_old[1] = s3_reg[17:9];

  dmm_pkg::dmm_tx_e tx_st_reg [2];
  logic [3:0] pre_cnt_reg [2];
  logic [3:0] txn_reg [2];
  logic [1:0] txe_reg;
  logic [5:0] hash_reg;
  logic [4:0] hash_out_reg;
  logic [1:0] rxv_reg;
  logic [1:0] dv_seen_reg;
  dmm_pkg::dmm_word_s rxw_reg [2];
  dmm_pkg::dmm_line_s [1:0] line_reg;

  // Outputs from flops
  assign port0_tx_nibble = txn_reg[0];
  assign port1_tx_nibble = txn_reg[1];
  assign port0_tx_enable = txe_reg[0];
  assign port1_tx_enable = txe_reg[1];
  assign line_status = line_reg;
  assign port1_hash = hash_reg; // [RQ15]

  genvar g;
  for (g = 0; g < 2; g++) begin : g_port
    wire txc_fall;
    wire rxc_rise;
    wire fifo_ready;
    wire fifo_valid;
    dmm_pkg::dmm_word_s fifo_word;
    wire pull;
    // Change on the falling edge so the PHY samples on the rising edge
    assign txc_fall = p_old[g][2] && !p_now[g][2]; // [RQ3]
    assign rxc_rise = p_now[g][3] && !p_old[g][3]; // [RQ5]
    assign pull = txc_fall && (tx_st_reg[g] == dmm_pkg::TX_DATA);

    dmm_fifo #(.WIDTH(5), .DEPTH(dmm_pkg::FIFO_DEPTH)) u_txq (
      .mclk(mclk),
      .arst_n(arst_n),
      .in_valid(tx_valid[g]),
      .in_ready(fifo_ready),
      .in_data(tx_word[g]),
      .out_valid(fifo_valid),
      .out_ready(pull),
      .out_data(fifo_word)
    );
    assign tx_ready[g] = fifo_ready;

    // Transmit sequencer: preamble, SFD, then queued nibbles
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        tx_st_reg[g] <= dmm_pkg::TX_IDLE;
        pre_cnt_reg[g] <= '0;
        txn_reg[g] <= '0;
        txe_reg[g] <= 1'b0;
      end else if (txc_fall) begin
        case (tx_st_reg[g])
          dmm_pkg::TX_IDLE: begin
            txe_reg[g] <= 1'b0;
            if (fifo_valid) begin
              tx_st_reg[g] <= dmm_pkg::TX_PRE;
              txn_reg[g] <= dmm_pkg::PRE_NIB;
              txe_reg[g] <= 1'b1; // [RQ4]
              pre_cnt_reg[g] <= 4'h1;
            end
          end
          dmm_pkg::TX_PRE: begin
            pre_cnt_reg[g] <= pre_cnt_reg[g] + 4'h1;
            if (pre_cnt_reg[g] == 4'(dmm_pkg::PRE_NIBS - 1)) begin
              tx_st_reg[g] <= dmm_pkg::TX_SFD;
            end
          end
          dmm_pkg::TX_SFD: begin
            txn_reg[g] <= dmm_pkg::SFD_NIB;
            tx_st_reg[g] <= dmm_pkg::TX_DATA;
          end
          dmm_pkg::TX_DATA: begin
            // An empty queue mid-frame ends the frame early
            txn_reg[g] <= fifo_word.nib;
            txe_reg[g] <= fifo_valid; // [RQ4]
            if (!fifo_valid || fifo_word.last) begin
              tx_st_reg[g] <= dmm_pkg::TX_IDLE;
            end
          end
          default: tx_st_reg[g] <= dmm_pkg::TX_IDLE;
        endcase
      end
    end

    // Receive capture; the last mark follows on the valid fall
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        rxv_reg[g] <= 1'b0;
        rxw_reg[g] <= '0;
        line_reg[g] <= '0;
        dv_seen_reg[g] <= 1'b0;
      end else begin
        line_reg[g] <= '{carrier: p_now[g][0], collision: p_now[g][1]};
        if (rx_ready[g]) rxv_reg[g] <= 1'b0;
        // Valid is steady around rises, so remember it from the last one
        if (rxc_rise) dv_seen_reg[g] <= p_now[g][8];
        if (rxc_rise && p_now[g][8]) begin
          rxw_reg[g] <= '{last: 1'b0, nib: p_now[g][7:4]}; // [RQ6]
          rxv_reg[g] <= 1'b1;
        end else if (rxc_rise && dv_seen_reg[g] && !rxw_reg[g].last) begin
          rxw_reg[g].last <= 1'b1;
          rxv_reg[g] <= 1'b1;
        end
      end
    end
    assign rx_valid[g] = rxv_reg[g];
    assign rx_word[g] = rxw_reg[g];
  end

  // Address hash on port 1 only: CRC-style fold over received nibbles
  wire rx1_take;
  wire [5:0] hash_base;
  assign rx1_take = rxv_reg[1] && rx_ready[1] && !rxw_reg[1].last;
  assign hash_base = (hash_out_reg == 5'h00) ? 6'h00 : hash_reg; // New frame
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hash_reg <= '0;
      hash_out_reg <= '0;
    end else if (rxv_reg[1] && rx_ready[1] && rxw_reg[1].last) begin
      hash_out_reg <= '0; // Result stays readable after the frame
    end else if (rx1_take && hash_out_reg < 5'h0c) begin
      // First twelve nibbles are the destination address
      hash_reg <= {hash_base[1:0], hash_base[5:2]} ^ {2'b00, rxw_reg[1].nib};
      hash_out_reg <= hash_out_reg + 5'h01; // [RQ15]
    end
  end
  // Port 0 carries no hash logic at all. [RQ14]

  // ----------------------------------------------------------------
  // Shared management interface
  // ----------------------------------------------------------------
  dmm_pkg::dmm_mg_e mg_st_reg;
  logic [7:0] div_reg;
  logic mdc_reg;
  logic [31:0] sh_reg;
  logic [31:0] oe_reg;
  logic [5:0] bit_reg;
  logic [31:0] rd_reg;
  wire mdc_rise;
  wire mdc_fall;
  wire div_hit;

  // Own divider drives the clock only when software enables it
  assign div_hit = (div_reg == dmm_pkg::MDC_HALF_C - 8'h01);
  assign mdc_rise = mgmt_clock_drive_en ? (div_hit && !mdc_reg) // [RQ12]
                                        : (m2_reg[1] && !mdc_old_reg);
  assign mdc_fall = mgmt_clock_drive_en ? (div_hit && mdc_reg)
                                        : (!m2_reg[1] && mdc_old_reg);
  assign mgmt_clock_line_o = mdc_reg;
  assign mgmt_clock_line_oe_n = !mgmt_clock_drive_en; // [RQ13]
  assign mgmt_data_line_o = sh_reg[31]; // [RQ11] [RQ16]
  assign mgmt_data_line_oe_n = !(mg_st_reg == dmm_pkg::MG_SHIFT && oe_reg[31]);
  assign mgmt_busy = (mg_st_reg != dmm_pkg::MG_IDLE);
  assign mgmt_read_data = rd_reg;

  // Clock divider
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= '0;
      mdc_reg <= 1'b0;
    end else if (!mgmt_clock_drive_en) begin
      div_reg <= '0;
      mdc_reg <= 1'b0;
    end else if (div_hit) begin
      div_reg <= '0;
      mdc_reg <= !mdc_reg;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // Shift engine: change data on falling edge, sample on rising edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mg_st_reg <= dmm_pkg::MG_IDLE;
      sh_reg <= '0;
      oe_reg <= '0;
      bit_reg <= '0;
      rd_reg <= '0;
    end else begin
      case (mg_st_reg)
        dmm_pkg::MG_IDLE: begin
          if (mgmt_start) begin
            sh_reg <= mgmt_frame;
            oe_reg <= mgmt_out_en;
            bit_reg <= '0;
            mg_st_reg <= dmm_pkg::MG_SHIFT;
          end
        end
        dmm_pkg::MG_SHIFT: begin
          if (mdc_rise && !oe_reg[31]) begin
            rd_reg <= {rd_reg[30:0], m2_reg[0]}; // [RQ12]
          end
          if (mdc_fall) begin
            sh_reg <= {sh_reg[30:0], 1'b0};
            oe_reg <= {oe_reg[30:0], 1'b0};
            bit_reg <= bit_reg + 6'h01;
            if (bit_reg == dmm_pkg::MGMT_BITS - 6'h01) begin
              mg_st_reg <= dmm_pkg::MG_DONE;
            end
          end
        end
        dmm_pkg::MG_DONE: mg_st_reg <= dmm_pkg::MG_IDLE;
        default: mg_st_reg <= dmm_pkg::MG_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- test/dmm_phy_model.sv ----
// Behavioural PHY: MII clocks, receive frames, transmit capture, mgmt reply
`timescale 1ns/1ps
`default_nettype none
module dmm_phy_model #(
  parameter realtime HALF = 80.0
) (
  // MII side
  output logic tx_clk,
  output logic rx_clk,
  input wire logic [3:0] tx_nib,
  input wire logic tx_en,
  output logic [3:0] rx_nib,
  output logic rx_dv,
  output logic col,
  output logic crs,
  // Management side
  input wire logic mdc,
  input wire logic [31:0] rd_pat,
  output logic mdio_q
);
  logic [3:0] cap[$];
  int nfall;
  // ----------------------------------------------------------------
  // Oscillator clocks, rx offset so the two never line up
  // ----------------------------------------------------------------
  initial begin
    tx_clk = 1'b0;
    forever #(HALF) tx_clk = ~tx_clk;
  end
  initial begin
    rx_clk = 1'b0;
    #37;
    forever #(HALF) rx_clk = ~rx_clk;
  end
  initial begin
    rx_nib = 4'ha;
    rx_dv = 1'b0;
    col = 1'b0;
    crs = 1'b0;
    nfall = 0;
  end
  // Transmit nibbles are taken on the rising tx clock
  always @(posedge tx_clk) if (tx_en) cap.push_back(tx_nib);
  // Reply bits move on mdc falls; the design samples on rises
  always @(negedge mdc) nfall <= nfall + 1;
  assign mdio_q = rd_pat[5'(31 - nfall)];
  // Receive frame; carrier rises with the first nibble, falls one rx clock after valid
  task automatic send(input logic [3:0] first, input int n, input logic c);
    @(negedge rx_clk);
    crs = 1'b1;
    col = c;
    for (int i = 0; i < n; i++) begin
      rx_dv = 1'b1;
      rx_nib = first + 4'(i);
      @(negedge rx_clk);
    end
    rx_dv = 1'b0;
    col = 1'b0;
    rx_nib = ~rx_nib; // Idle bus shows no stale value
    @(negedge rx_clk);
    crs = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- test/dmm_port_checker.sv ----
// Concurrent checks on the dual MII port pins and management line
`timescale 1ns/1ps
`default_nettype none
module dmm_port_checker (
  // Core clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Port pins and status
  input wire logic port0_tx_clock_in,
  input wire logic [3:0] port0_tx_nibble,
  input wire logic port0_tx_enable,
  input wire logic port0_rx_valid,
  input wire logic port0_carrier_sense,
  input wire logic [1:0] rx_valid,
  input wire dmm_pkg::dmm_line_s [1:0] line_status,
  // Management
  input wire logic mgmt_data_line_o,
  input wire logic mgmt_data_line_oe_n,
  input wire logic mgmt_clock_line_o,
  input wire logic mgmt_clock_line_oe_n,
  input wire logic mgmt_clock_drive_en,
  input wire logic mgmt_start,
  input wire logic [31:0] mgmt_frame,
  input wire logic [31:0] mgmt_out_en,
  input wire logic mgmt_busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [7:0] dv_age_reg;
  // Cycles since receive valid was last seen, saturating
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dv_age_reg <= 8'hff;
    end else begin
      dv_age_reg <= port0_rx_valid ? 8'h00 :
        (dv_age_reg == 8'hff ? dv_age_reg : dv_age_reg + 8'h01);
    end
  end
  // A command accepted from idle with the own divider running
  sequence s_take;
    mgmt_start && !mgmt_busy && !$past(mgmt_busy) && mgmt_clock_drive_en;
  endsequence
  sequence s_run;
    mgmt_busy[*8];
  endsequence
  // Busy cycles of one transfer; a counter keeps the long bound cheap
  logic [10:0] busy_cnt_reg;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      busy_cnt_reg <= 11'h000;
    end else begin
      busy_cnt_reg <= mgmt_busy ? busy_cnt_reg + 11'h001 : 11'h000;
    end
  end
  chk_busy_bound: assert property (busy_cnt_reg <= 11'h6a4)
    else $error("mgmt transfer did not finish in time");
  chk_mgmt_busy: assert property (s_take |=> s_run)
    else $error("mgmt busy wrong after start");
  chk_first_bit: assert property (s_take |=>
    mgmt_data_line_o == $past(mgmt_frame[31]) &&
    mgmt_data_line_oe_n == !$past(mgmt_out_en[31]))
    else $error("first mgmt bit wrong");
  chk_rise_stable: assert property ($rose(mgmt_clock_line_o) |->
    $stable(mgmt_data_line_o) && $stable(mgmt_data_line_oe_n))
    else $error("mgmt data moved on clock rise");
  chk_mdc_half: assert property ($changed(mgmt_clock_line_o) |=>
    $stable(mgmt_clock_line_o)[*8])
    else $error("mgmt clock half period short");
  chk_clk_input: assert property (!mgmt_clock_drive_en &&
    !$past(mgmt_clock_drive_en) |-> mgmt_clock_line_oe_n)
    else $error("mgmt clock pin driven without enable");
  chk_tx_on_fall: assert property ($changed(port0_tx_nibble) ||
    $changed(port0_tx_enable) |-> !port0_tx_clock_in)
    else $error("tx output moved while tx clock high");
  chk_tx_preamble: assert property ($rose(port0_tx_enable) |->
    port0_tx_nibble == dmm_pkg::PRE_NIB)
    else $error("tx enable rose without preamble");
  chk_carrier_sync: assert property ($rose(port0_carrier_sense) |->
    ##[2:40] line_status[0].carrier)
    else $error("carrier not reported");
  chk_rx_cause: assert property ($rose(rx_valid[0]) |->
    dv_age_reg < 8'h40)
    else $error("rx word without receive valid");
endmodule
bind dmm_port dmm_port_checker chk_u (.*);
`default_nettype wire

// ---- test/tb_top.sv ----
// Bench: two PHY models, management line, one task per scenario
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk, arst_n, mgmt_clock_drive_en, mgmt_start, mdio_q;
  logic mgmt_data_line_o, mgmt_data_line_oe_n, mgmt_busy;
  logic mgmt_clock_line_o, mgmt_clock_line_oe_n, mdio_line, mdc_line;
  logic [31:0] mgmt_frame, mgmt_out_en, mgmt_read_data, rd_pat;
  logic [1:0] tx_valid, tx_ready, rx_valid, rx_ready;
  logic [5:0] port1_hash;
  logic port0_tx_clock_in, port0_tx_enable, port0_rx_clock_in;
  logic port0_rx_valid, port0_collision, port0_carrier_sense;
  logic port1_tx_clock_in, port1_tx_enable, port1_rx_clock_in;
  logic port1_rx_valid, port1_collision, port1_carrier_sense;
  logic [3:0] port0_tx_nibble, port0_rx_nibble;
  logic [3:0] port1_tx_nibble, port1_rx_nibble;
  dmm_pkg::dmm_word_s [1:0] tx_word, rx_word;
  dmm_pkg::dmm_line_s [1:0] line_status;
  dmm_pkg::dmm_word_s rq0[$], rq1[$];
  logic [1:0] tx_en_w;
  int miscompares = 0;
  int n_tests = 0;
  // Pins: PHY answers on the data line only where the design lets go
  assign mdio_line = !mgmt_data_line_oe_n ? mgmt_data_line_o : mdio_q;
  assign mdc_line = !mgmt_clock_line_oe_n ? mgmt_clock_line_o : 1'b0;
  assign tx_en_w = {port1_tx_enable, port0_tx_enable};
  dmm_port dut_u (.*, .mgmt_data_line_i(mdio_line),
    .mgmt_clock_line_i(mdc_line));
  dmm_phy_model phy0_u (.tx_clk(port0_tx_clock_in),
    .rx_clk(port0_rx_clock_in), .tx_nib(port0_tx_nibble),
    .tx_en(port0_tx_enable), .rx_nib(port0_rx_nibble),
    .rx_dv(port0_rx_valid), .col(port0_collision),
    .crs(port0_carrier_sense), .mdc(mdc_line), .rd_pat(rd_pat),
    .mdio_q(mdio_q));
  dmm_phy_model phy1_u (.tx_clk(port1_tx_clock_in),
    .rx_clk(port1_rx_clock_in), .tx_nib(port1_tx_nibble),
    .tx_en(port1_tx_enable), .rx_nib(port1_rx_nibble),
    .rx_dv(port1_rx_valid), .col(port1_collision),
    .crs(port1_carrier_sense), .mdc(mdc_line), .rd_pat(rd_pat),
    .mdio_q());
  // Collect receive words half a cycle before the taking edge
  always @(negedge mclk) begin
    if (rx_valid[0] && rx_ready[0]) rq0.push_back(rx_word[0]);
    if (rx_valid[1] && rx_ready[1]) rq1.push_back(rx_word[1]);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Counts: mismatches=%0d compares=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tmo();
    miscompares++;
    wrap_up();
  endtask
  // Valid stays up between words so it is never set twice in a step
  task automatic push(input int p, input logic [4:0] w);
    int n;
    n = 0;
    tx_word[p] = w;
    tx_valid[p] = 1'b1;
    while (tx_ready[p] !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 2000) tmo();
    @(posedge mclk);
    #1;
  endtask
  // Fill the queue to refusal, then read the whole frame off the pins
  task automatic tx_scn(input int p);
    logic [3:0] q[$];
    int n;
    for (int i = 0; i < 8; i++) push(p, {i == 7, 4'(i + 3)});
    tx_valid[p] = 1'b0;
    chk(tx_ready[p], 0);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      if (p) q = phy1_u.cap;
      else q = phy0_u.cap;
      n++;
    end while ((q.size() < 24 || tx_en_w[p]) && n < 1500);
    if (n == 1500) tmo();
    chk(q.size(), 24);
    foreach (q[i]) chk(q[i], i < 15 ? dmm_pkg::PRE_NIB :
      (i == 15 ? dmm_pkg::SFD_NIB : 4'(i - 13)));
  endtask
  // Frame of 12 nibbles; status checked mid-frame and after carrier drops
  task automatic rx_scn(input int p, input logic c);
    dmm_pkg::dmm_word_s q[$];
    fork
      if (p) phy1_u.send(4'h9, 12, c);
      else phy0_u.send(4'h9, 12, c);
      begin
        repeat (120) @(posedge mclk);
        #1;
        chk(line_status[p], {1'b1, c});
      end
    join
    repeat (80) @(posedge mclk);
    #1;
    chk(line_status[p], 0);
    if (p) q = rq1;
    else q = rq0;
    chk(q.size(), 13);
    foreach (q[i]) chk(q[i], {i == 12, 4'(9 + (i > 11 ? 11 : i))});
    chk(port1_hash, p ? 32'h0000_0021 : 32'h0000_0000);
  endtask
  // One management transfer; read bits come where drive enable is 0
  task automatic mg_scn(input logic [31:0] f, input logic [31:0] e);
    int n;
    n = 0;
    mgmt_frame = f;
    mgmt_out_en = e;
    phy0_u.nfall = 0;
    mgmt_start = 1'b1;
    @(posedge mclk);
    #1;
    mgmt_start = 1'b0;
    chk(mgmt_busy, 1);
    while (mgmt_busy !== 1'b0 && n < 2000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 2000) tmo();
    chk(mgmt_read_data, rd_pat & ~e);
    chk(mgmt_data_line_oe_n, 1);
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    tmo();
  end
  initial begin
    arst_n = 1'b0;
    mgmt_clock_drive_en = 1'b0;
    mgmt_start = 1'b0;
    mgmt_frame = 32'h0000_0000;
    mgmt_out_en = 32'h0000_0000;
    rd_pat = 32'h3c5a_96e1;
    tx_valid = 2'b00;
    tx_word = '0;
    rx_ready = 2'b11;
    repeat (5) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    chk(mgmt_clock_line_oe_n, 1);
    chk(mgmt_data_line_oe_n, 1);
    for (int p = 0; p < 2; p++) begin
      tx_scn(p);
      rx_scn(p, 1'(p));
    end
    mgmt_clock_drive_en = 1'b1;
    @(posedge mclk);
    #1;
    chk(mgmt_clock_line_oe_n, 0);
    mg_scn(32'h5002_1234, 32'hffff_ffff);
    mg_scn(32'h6012_0000, 32'hfffc_0000);
    wrap_up();
  end
endmodule
`default_nettype wire
